// file: common/pdlc_regs.vh
// register offsets, field positions, reset values and frame timing
// assumes inclusion by every design file of the power-down and lock block
`ifndef PDLC_REGS_VH
`define PDLC_REGS_VH

// ****************************************
// offsets
// ****************************************
`define PDLC_ADDR_W            15
`define PDLC_OFS_OUT_PWR       15'h0019
`define PDLC_OFS_BLOCK_PD      15'h001a
`define PDLC_OFS_LOCK_CFG      15'h001b
`define PDLC_OFS_CAL_CLK       15'h001c

// ****************************************
// reset values
// ****************************************
`define PDLC_RST_OUT_PWR       8'h04
`define PDLC_RST_BLOCK_PD      8'h83
`define PDLC_RST_LOCK_CFG      8'h00
`define PDLC_RST_CAL_CLK       8'h00

// ****************************************
// output_and_power_config fields
// ****************************************
`define PDLC_OP_AMP_HI         5
`define PDLC_OP_AMP_LO         4
`define PDLC_OP_CLK_PD         3
`define PDLC_OP_REFDET_PD      2
`define PDLC_OP_ADC_PD         1
`define PDLC_OP_CALDAC_PD      0

// ****************************************
// block_power_down fields
// ****************************************
`define PDLC_BP_MAIN           7
`define PDLC_BP_REFDIV         6
`define PDLC_BP_FBDIV          5
`define PDLC_BP_OSC            4
`define PDLC_BP_LOCKDET        3
`define PDLC_BP_PUMP           2
`define PDLC_BP_CLKBUF         1
`define PDLC_BP_PULSE          0

// ****************************************
// lock_detect_config fields
// ****************************************
`define PDLC_LC_LOL_EN         7
`define PDLC_LC_WIDE           6
`define PDLC_LC_WIN_ON         5
`define PDLC_LC_TGT_HI         4
`define PDLC_LC_TGT_LO         0

// ****************************************
// calibration_clock_control fields
// ****************************************
`define PDLC_CC_DIV_ON         7
`define PDLC_CC_CONV_DIV_ON    6
`define PDLC_CC_FORCE_UNLK     2

// ****************************************
// serial frame
// ****************************************
`define PDLC_HDR_BITS          5'd16
`define PDLC_FRAME_BITS        5'd24

`endif

// file: rtl/pdlc_spi_slave.v
// serial port slave: read/write bit, 15-bit address, 8 data bits, msb first
// assumes sclk, csb and sdi already synchronised to i_clk
`include "pdlc_regs.vh"

module pdlc_spi_slave (
  input  wire                     i_clk,
  input  wire                     i_rstn,
  input  wire                     i_sclk_s,
  input  wire                     i_csb_s,
  input  wire                     i_sdi_s,
  input  wire [7:0]               i_rdata,
  output reg  [`PDLC_ADDR_W-1:0]  o_addr_q,
  output reg                      o_wr_q,
  output reg  [7:0]               o_wdata_q,
  output reg                      o_sdo_q,
  output reg                      o_sdo_en_n_q
);

  // ****************************************
  // frame state
  // ****************************************
  reg        sclk_prev_q;
  reg [4:0]  cnt_q;
  reg [22:0] in_q;
  reg        rd_q;
  reg        load_q;
  reg [7:0]  out_q;
  wire       rise;
  wire       fall;

  assign rise = i_sclk_s & ~sclk_prev_q;
  assign fall = ~i_sclk_s & sclk_prev_q;

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sclk_prev_q  <= 1'b0;
      cnt_q        <= 5'd0;
      in_q         <= 23'h000000;
      rd_q         <= 1'b0;
      load_q       <= 1'b0;
      out_q        <= 8'h00;
      o_addr_q     <= 15'h0000;
      o_wr_q       <= 1'b0;
      o_wdata_q    <= 8'h00;
      o_sdo_q      <= 1'b0;
      o_sdo_en_n_q <= 1'b1;
    end else begin
      sclk_prev_q <= i_sclk_s;
      o_wr_q      <= 1'b0;
      load_q      <= 1'b0;
      if (load_q) begin
        out_q <= i_rdata;
      end
      if (i_csb_s) begin
        cnt_q        <= 5'd0;
        rd_q         <= 1'b0;
        o_sdo_en_n_q <= 1'b1;
      end else begin
        if (rise && cnt_q < `PDLC_FRAME_BITS) begin
          in_q  <= {in_q[21:0], i_sdi_s};
          cnt_q <= cnt_q + 5'd1;
          if (cnt_q == `PDLC_HDR_BITS - 5'd1) begin
            o_addr_q <= {in_q[13:0], i_sdi_s};
            rd_q     <= in_q[14];
            load_q   <= in_q[14];
          end
          if (cnt_q == `PDLC_FRAME_BITS - 5'd1 && !rd_q) begin
            o_wr_q    <= 1'b1;
            o_wdata_q <= {in_q[6:0], i_sdi_s};
          end
        end
        if (fall && rd_q && cnt_q >= `PDLC_HDR_BITS && cnt_q < `PDLC_FRAME_BITS) begin
          o_sdo_q      <= out_q[7];
          out_q        <= {out_q[6:0], 1'b0};
          o_sdo_en_n_q <= 1'b0;
        end
        if (fall && cnt_q >= `PDLC_FRAME_BITS) begin
          o_sdo_en_n_q <= 1'b1;
        end
      end
    end
  end

endmodule // pdlc_spi_slave

// file: rtl/pdlc_lock_detect.v
// lock detector: counts valid phase detector cycles up to a target
// assumes i_cycle is a one-cycle pulse and window flags are synchronised
`include "pdlc_regs.vh"

module pdlc_lock_detect #(
  parameter CNT_W = 5
) (
  input  wire             i_clk,
  input  wire             i_rstn,
  input  wire             i_cycle,
  input  wire             i_in_narrow,
  input  wire             i_in_wide,
  input  wire             i_window_wide,
  input  wire             i_window_on,
  input  wire [CNT_W-1:0] i_target,
  input  wire             i_lol_en,
  input  wire             i_hold,
  output reg              o_locked_q
);

  // ****************************************
  // counting
  // ****************************************
  reg  [CNT_W-1:0] cnt_q;
  wire             valid;

  assign valid = ~i_window_on | (i_window_wide ? i_in_wide : i_in_narrow); // RL6 RL7

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_q      <= {CNT_W{1'b0}};
      o_locked_q <= 1'b0;
    end else if (i_hold) begin
      cnt_q      <= {CNT_W{1'b0}}; // RL9
      o_locked_q <= 1'b0; // RL9
    end else if (i_cycle) begin
      if (valid) begin
        if (!o_locked_q) begin
          if (cnt_q == i_target) begin
            o_locked_q <= 1'b1; // RL8
          end else begin
            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}; // RL8
          end
        end
      end else begin
        cnt_q <= {CNT_W{1'b0}};
        if (i_lol_en || !o_locked_q) begin
          o_locked_q <= 1'b0;
        end
      end
    end
  end

endmodule // pdlc_lock_detect

// file: rtl/pdlc_top.v
// power-down and lock control register bank reached over the serial port
// assumes pins and analog flags are asynchronous to i_clk; enables feed analog blocks
//
// Behaviour
// RL1: main sleep resets to 1 and powers down everything while keeping all register contents.
// RL2: bits 6 to 2 of block_power_down each put one block to sleep when 1.
// RL3: bit 0 of output_and_power_config sleeps the calibration DAC and resets to 0.
// RL4: the clock buffer sleep bit resets to 1 and writing 0 enables the clock output.
// RL5: the pulse output sleep bit resets to 1 and writing 0 enables the pulse output.
// RL6: lock window wide bit picks the wide window when 1 and the narrow one when 0.
// RL7: lock window on bit enables the pulse window when 1 and resets to 0.
// RL8: the five-bit target sets how many valid cycles pass before lock is reported.
// RL9: force unlocked holds the detector unlocked until software writes it back to 0.
// RL10: software sets the calibration divider enable before a calibration and clears it after.
// RL11: software sets the converter divider enable before a calibration or measurement.
// RL12: software should clear both divider enables when idle to limit spurs.
// RL13: every field reads back its last written or reset value and drives its enable continuously.
`include "pdlc_regs.vh"

module pdlc_top #(
  parameter TGT_W = 5
) (
  input  wire       i_clk,
  input  wire       i_rstn,
  input  wire       i_sclk,
  input  wire       i_csb,
  input  wire       i_sdi,
  output reg        o_sdo,
  output reg        o_sdo_en_n,
  input  wire       i_pfd_tick,
  input  wire       i_in_narrow,
  input  wire       i_in_wide,
  output reg        o_main_sleep,
  output reg        o_ref_divider_sleep,
  output reg        o_feedback_divider_sleep,
  output reg        o_oscillator_sleep,
  output reg        o_lock_detector_sleep,
  output reg        o_phase_detector_pump_sleep,
  output reg        o_clock_buffer_sleep,
  output reg        o_pulse_output_sleep,
  output reg        o_calibration_dac_sleep,
  output reg        o_clock_divider_sleep,
  output reg        o_ref_detector_sleep,
  output reg        o_adc_sleep,
  output reg  [1:0] o_clock_amplitude,
  output reg        o_calibration_divider_on,
  output reg        o_calibration_converter_divider_on,
  output reg        o_lock_window_wide,
  output reg        o_lock_window_on,
  output reg  [4:0] o_lock_cycle_target,
  output reg        o_lock_force_unlocked,
  output reg        o_locked
);

  // ****************************************
  // input synchronisers
  // ****************************************
  reg [5:0] sync1_q;
  reg [5:0] sync2_q;
  reg       tick_prev_q;
  wire      sclk_s;
  wire      csb_s;
  wire      sdi_s;
  wire      tick_s;
  wire      narrow_s;
  wire      wide_s;
  wire      pfd_cycle;

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sync1_q     <= 6'h02;
      sync2_q     <= 6'h02;
      tick_prev_q <= 1'b0;
    end else begin
      sync1_q     <= {i_in_wide, i_in_narrow, i_pfd_tick, i_sdi, i_csb, i_sclk};
      sync2_q     <= sync1_q;
      tick_prev_q <= sync2_q[3];
    end
  end

  assign sclk_s    = sync2_q[0];
  assign csb_s     = sync2_q[1];
  assign sdi_s     = sync2_q[2];
  assign tick_s    = sync2_q[3];
  assign narrow_s  = sync2_q[4];
  assign wide_s    = sync2_q[5];
  assign pfd_cycle = tick_s & ~tick_prev_q;

  // ****************************************
  // serial port
  // ****************************************
  wire [`PDLC_ADDR_W-1:0] addr;
  wire                    wr;
  wire [7:0]              wdata;
  wire [7:0]              rdata;
  wire                    sdo;
  wire                    sdo_en_n;

  pdlc_spi_slave u_spi (
    .i_clk        (i_clk),
    .i_rstn       (i_rstn),
    .i_sclk_s     (sclk_s),
    .i_csb_s      (csb_s),
    .i_sdi_s      (sdi_s),
    .i_rdata      (rdata),
    .o_addr_q     (addr),
    .o_wr_q       (wr),
    .o_wdata_q    (wdata),
    .o_sdo_q      (sdo),
    .o_sdo_en_n_q (sdo_en_n)
  );

  // ****************************************
  // register file
  // ****************************************
  reg [7:0] out_pwr_q;
  reg [7:0] block_pd_q;
  reg [7:0] lock_cfg_q;
  reg [7:0] cal_clk_q;

  function [1:0] dec;
    input [`PDLC_ADDR_W-1:0] a;
    begin
      case (a)
        `PDLC_OFS_OUT_PWR:  dec = 2'd0;
        `PDLC_OFS_BLOCK_PD: dec = 2'd1;
        `PDLC_OFS_LOCK_CFG: dec = 2'd2;
        `PDLC_OFS_CAL_CLK:  dec = 2'd3;
        default:            dec = 2'd0;
      endcase
    end
  endfunction

  function hit;
    input [`PDLC_ADDR_W-1:0] a;
    begin
      hit = (a >= `PDLC_OFS_OUT_PWR) && (a <= `PDLC_OFS_CAL_CLK);
    end
  endfunction

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      out_pwr_q <= `PDLC_RST_OUT_PWR; // RL3
    end else if (wr && hit(addr) && dec(addr) == 2'd0) begin
      out_pwr_q <= wdata; // RL13
    end
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      block_pd_q <= `PDLC_RST_BLOCK_PD; // RL1 RL4 RL5
    end else if (wr && hit(addr) && dec(addr) == 2'd1) begin
      block_pd_q <= wdata; // RL13
    end
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lock_cfg_q <= `PDLC_RST_LOCK_CFG; // RL7
    end else if (wr && hit(addr) && dec(addr) == 2'd2) begin
      lock_cfg_q <= wdata; // RL13
    end
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cal_clk_q <= `PDLC_RST_CAL_CLK;
    end else if (wr && hit(addr) && dec(addr) == 2'd3) begin
      cal_clk_q <= wdata; // RL13
    end
  end

  reg [7:0] rd_mux;

  always @* begin
    rd_mux = 8'h00;
    if (hit(addr)) begin
      case (dec(addr))
        2'd0:    rd_mux = out_pwr_q; // RL13
        2'd1:    rd_mux = block_pd_q; // RL13
        2'd2:    rd_mux = lock_cfg_q; // RL13
        2'd3:    rd_mux = cal_clk_q; // RL13
        default: rd_mux = 8'h00;
      endcase
    end
  end

  assign rdata = rd_mux;

  // ****************************************
  // lock detector
  // ****************************************
  wire main_sleep;
  wire ld_hold;
  wire locked;

  assign main_sleep = block_pd_q[`PDLC_BP_MAIN];
  assign ld_hold    = cal_clk_q[`PDLC_CC_FORCE_UNLK] | main_sleep | block_pd_q[`PDLC_BP_LOCKDET]; // RL9

  pdlc_lock_detect #(
    .CNT_W (TGT_W)
  ) u_ld (
    .i_clk         (i_clk),
    .i_rstn        (i_rstn),
    .i_cycle       (pfd_cycle),
    .i_in_narrow   (narrow_s),
    .i_in_wide     (wide_s),
    .i_window_wide (lock_cfg_q[`PDLC_LC_WIDE]),
    .i_window_on   (lock_cfg_q[`PDLC_LC_WIN_ON]),
    .i_target      (lock_cfg_q[`PDLC_LC_TGT_HI:`PDLC_LC_TGT_LO]),
    .i_lol_en      (lock_cfg_q[`PDLC_LC_LOL_EN]),
    .i_hold        (ld_hold),
    .o_locked_q    (locked)
  );

  // ****************************************
  // serial data out
  // ****************************************
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sdo      <= 1'b0;
      o_sdo_en_n <= 1'b1;
    end else begin
      o_sdo      <= sdo;
      o_sdo_en_n <= sdo_en_n;
    end
  end

  // ****************************************
  // registered sleep enables
  // ****************************************
  function gate_sleep;
    input all_sleep;
    input own_sleep;
    begin
      gate_sleep = all_sleep | own_sleep;
    end
  endfunction

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_main_sleep                <= 1'b1;
      o_ref_divider_sleep         <= 1'b1;
      o_feedback_divider_sleep    <= 1'b1;
      o_oscillator_sleep          <= 1'b1;
      o_lock_detector_sleep       <= 1'b1;
      o_phase_detector_pump_sleep <= 1'b1;
      o_clock_buffer_sleep        <= 1'b1;
      o_pulse_output_sleep        <= 1'b1;
      o_calibration_dac_sleep     <= 1'b1;
      o_clock_divider_sleep       <= 1'b1;
      o_ref_detector_sleep        <= 1'b1;
      o_adc_sleep                 <= 1'b1;
      o_clock_amplitude           <= 2'h0;
    end else begin
      o_main_sleep                <= main_sleep; // RL1
      o_ref_divider_sleep         <= gate_sleep(main_sleep, block_pd_q[`PDLC_BP_REFDIV]); // RL1 RL2
      o_feedback_divider_sleep    <= gate_sleep(main_sleep, block_pd_q[`PDLC_BP_FBDIV]); // RL1 RL2
      o_oscillator_sleep          <= gate_sleep(main_sleep, block_pd_q[`PDLC_BP_OSC]); // RL1 RL2
      o_lock_detector_sleep       <= gate_sleep(main_sleep, block_pd_q[`PDLC_BP_LOCKDET]); // RL1 RL2
      o_phase_detector_pump_sleep <= gate_sleep(main_sleep, block_pd_q[`PDLC_BP_PUMP]); // RL1 RL2
      o_clock_buffer_sleep        <= gate_sleep(main_sleep, block_pd_q[`PDLC_BP_CLKBUF]); // RL1 RL4
      o_pulse_output_sleep        <= gate_sleep(main_sleep, block_pd_q[`PDLC_BP_PULSE]); // RL1 RL5
      o_calibration_dac_sleep     <= gate_sleep(main_sleep, out_pwr_q[`PDLC_OP_CALDAC_PD]); // RL1 RL3
      o_clock_divider_sleep       <= gate_sleep(main_sleep, out_pwr_q[`PDLC_OP_CLK_PD]); // RL1
      o_ref_detector_sleep        <= gate_sleep(main_sleep, out_pwr_q[`PDLC_OP_REFDET_PD]); // RL1
      o_adc_sleep                 <= gate_sleep(main_sleep, out_pwr_q[`PDLC_OP_ADC_PD]); // RL1
      o_clock_amplitude           <= out_pwr_q[`PDLC_OP_AMP_HI:`PDLC_OP_AMP_LO];
    end
  end

  // ****************************************
  // calibration divider enables
  // ****************************************
  function gate_on;
    input all_sleep;
    input own_on;
    begin
      gate_on = ~all_sleep & own_on;
    end
  endfunction

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_calibration_divider_on           <= 1'b0;
      o_calibration_converter_divider_on <= 1'b0;
    end else begin
      o_calibration_divider_on           <= gate_on(main_sleep, cal_clk_q[`PDLC_CC_DIV_ON]); // RL1
      o_calibration_converter_divider_on <= gate_on(main_sleep, cal_clk_q[`PDLC_CC_CONV_DIV_ON]); // RL1
    end
  end

  // ****************************************
  // lock field mirrors
  // ****************************************
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_lock_window_wide    <= 1'b0;
      o_lock_window_on      <= 1'b0;
      o_lock_cycle_target   <= 5'h00;
      o_lock_force_unlocked <= 1'b0;
      o_locked              <= 1'b0;
    end else begin
      o_lock_window_wide    <= lock_cfg_q[`PDLC_LC_WIDE]; // RL6
      o_lock_window_on      <= lock_cfg_q[`PDLC_LC_WIN_ON]; // RL7
      o_lock_cycle_target   <= lock_cfg_q[`PDLC_LC_TGT_HI:`PDLC_LC_TGT_LO]; // RL8
      o_lock_force_unlocked <= cal_clk_q[`PDLC_CC_FORCE_UNLK]; // RL9
      o_locked              <= locked;
    end
  end

endmodule // pdlc_top

// file: test/pdlc_top_assertions.sv
// port checker of the power-down and lock control bank
// assumes binding onto pdlc_top, single clock domain
module pdlc_top_assertions #(
  parameter TGT_W = 5
) (
  input wire       i_clk,
  input wire       i_rstn,
  input wire       i_sclk,
  input wire       i_csb,
  input wire       i_pfd_tick,
  input wire       o_sdo_en_n,
  input wire       o_main_sleep,
  input wire       o_ref_divider_sleep,
  input wire       o_feedback_divider_sleep,
  input wire       o_oscillator_sleep,
  input wire       o_lock_detector_sleep,
  input wire       o_phase_detector_pump_sleep,
  input wire       o_clock_buffer_sleep,
  input wire       o_pulse_output_sleep,
  input wire       o_calibration_dac_sleep,
  input wire       o_clock_divider_sleep,
  input wire       o_ref_detector_sleep,
  input wire       o_adc_sleep,
  input wire       o_calibration_divider_on,
  input wire       o_calibration_converter_divider_on,
  input wire       o_lock_window_wide,
  input wire       o_lock_window_on,
  input wire [4:0] o_lock_cycle_target,
  input wire       o_lock_force_unlocked,
  input wire       o_locked
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // helpers
  // ****************************************
  wire [11:0] sleeps = {o_main_sleep, o_ref_divider_sleep, o_feedback_divider_sleep, o_oscillator_sleep,
                        o_lock_detector_sleep, o_phase_detector_pump_sleep, o_clock_buffer_sleep,
                        o_pulse_output_sleep, o_calibration_dac_sleep, o_clock_divider_sleep,
                        o_ref_detector_sleep, o_adc_sleep};
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  sequence s_tick_quiet;
    (!o_locked && $stable(i_pfd_tick)) [*8];
  endsequence
  sequence s_bus_quiet;
    ($stable(i_sclk) && i_csb) [*8];
  endsequence
  // ****************************************
  // properties
  // ****************************************
  chk_sleep_gate: assert property (o_main_sleep |-> &sleeps)
    else $error("main sleep does not hold every block asleep");
  chk_div_gate: assert property (o_main_sleep |-> !(o_calibration_divider_on || o_calibration_converter_divider_on))
    else $error("divider enable active under main sleep");
  chk_reset_vals: assert property ($rose(i_rstn) |-> o_main_sleep && o_clock_buffer_sleep && o_pulse_output_sleep && !o_lock_window_on)
    else $error("outputs wrong after reset release");
  chk_force_unlk: assert property (o_lock_force_unlocked |=> !o_locked)
    else $error("locked while forced unlocked");
  chk_ld_sleep: assert property (o_lock_detector_sleep |=> !o_locked)
    else $error("locked while lock detector asleep");
  chk_lock_tick: assert property (s_tick_quiet |=> !o_locked)
    else $error("lock reported without a detector cycle");
  chk_sdo_idle: assert property (i_csb [*4] |-> o_sdo_en_n)
    else $error("sdo driven while not selected");
  chk_cfg_stable: assert property (s_bus_quiet |=> $stable({o_lock_window_wide, o_lock_window_on, o_lock_cycle_target}))
    else $error("lock fields changed without a write");
  chk_sleep_stable: assert property (s_bus_quiet |=> $stable(sleeps))
    else $error("sleep outputs changed without a write");
endmodule // pdlc_top_assertions

bind pdlc_top pdlc_top_assertions #(.TGT_W(TGT_W)) u_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_sclk(i_sclk), .i_csb(i_csb), .i_pfd_tick(i_pfd_tick),
  .o_sdo_en_n(o_sdo_en_n), .o_main_sleep(o_main_sleep), .o_ref_divider_sleep(o_ref_divider_sleep),
  .o_feedback_divider_sleep(o_feedback_divider_sleep), .o_oscillator_sleep(o_oscillator_sleep),
  .o_lock_detector_sleep(o_lock_detector_sleep), .o_phase_detector_pump_sleep(o_phase_detector_pump_sleep),
  .o_clock_buffer_sleep(o_clock_buffer_sleep), .o_pulse_output_sleep(o_pulse_output_sleep),
  .o_calibration_dac_sleep(o_calibration_dac_sleep), .o_clock_divider_sleep(o_clock_divider_sleep),
  .o_ref_detector_sleep(o_ref_detector_sleep), .o_adc_sleep(o_adc_sleep),
  .o_calibration_divider_on(o_calibration_divider_on),
  .o_calibration_converter_divider_on(o_calibration_converter_divider_on),
  .o_lock_window_wide(o_lock_window_wide), .o_lock_window_on(o_lock_window_on),
  .o_lock_cycle_target(o_lock_cycle_target), .o_lock_force_unlocked(o_lock_force_unlocked), .o_locked(o_locked));

// file: test/tb_power_down_and_lock_control.sv
// self-checking bench of the power-down and lock control bank
// assumes pdlc_top with a 1+15+8 bit serial frame, msb first
`include "pdlc_regs.vh"
module tb_power_down_and_lock_control;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals
  // ****************************************
  logic        i_clk = 0, i_rstn = 0, i_sclk = 0, i_csb = 1, i_sdi = 0;
  logic        i_pfd_tick = 0, i_in_narrow = 0, i_in_wide = 0;
  wire         o_sdo, o_sdo_en_n, div_on, conv_on, win_w, win_on, force_u, locked;
  wire  [11:0] sl;
  wire  [1:0]  amp;
  wire  [4:0]  tgt;
  logic [7:0]  r19 = 8'h04, r1a = 8'h83, r1b = 8'h00, r1c = 8'h00, rd_val, dmy;
  logic [7:0]  exp_q[$];
  string       nm_q[$];
  int          err_total = 0, check_count = 0, seed = 12936;
  event        rd_evt;

  pdlc_top #(.TGT_W(5)) i_dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_sclk(i_sclk), .i_csb(i_csb), .i_sdi(i_sdi),
    .o_sdo(o_sdo), .o_sdo_en_n(o_sdo_en_n), .i_pfd_tick(i_pfd_tick), .i_in_narrow(i_in_narrow),
    .i_in_wide(i_in_wide), .o_main_sleep(sl[11]), .o_ref_divider_sleep(sl[10]),
    .o_feedback_divider_sleep(sl[9]), .o_oscillator_sleep(sl[8]), .o_lock_detector_sleep(sl[7]),
    .o_phase_detector_pump_sleep(sl[6]), .o_clock_buffer_sleep(sl[5]), .o_pulse_output_sleep(sl[4]),
    .o_calibration_dac_sleep(sl[3]), .o_clock_divider_sleep(sl[2]), .o_ref_detector_sleep(sl[1]),
    .o_adc_sleep(sl[0]), .o_clock_amplitude(amp), .o_calibration_divider_on(div_on),
    .o_calibration_converter_divider_on(conv_on), .o_lock_window_wide(win_w), .o_lock_window_on(win_on),
    .o_lock_cycle_target(tgt), .o_lock_force_unlocked(force_u), .o_locked(locked));

  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic wait_c(int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [7:0] shadow(logic [14:0] a);
    case (a)
      15'h0019: return r19;
      15'h001a: return r1a;
      15'h001b: return r1b;
      15'h001c: return r1c;
      default:  return 8'h00;
    endcase
  endfunction
  task automatic frame(logic rw, logic [14:0] a, logic [7:0] d, output logic [7:0] q);
    logic [23:0] w;
    w = {rw, a, d};
    i_csb <= 1'b0;
    wait_c(6);
    for (int i = 23; i >= 0; i--) begin
      i_sdi <= w[i];
      wait_c(6);
      i_sclk <= 1'b1;
      wait_c(6);
      q = {q[6:0], o_sdo};
      chk("sdo enable", o_sdo_en_n, !(rw && i < 8));
      i_sclk <= 1'b0;
    end
    wait_c(6);
    i_csb <= 1'b1;
    wait_c(10);
  endtask
  task automatic wr(logic [14:0] a, logic [7:0] d);
    frame(1'b0, a, d, dmy);
    case (a)
      15'h0019: r19 = d;
      15'h001a: r1a = d;
      15'h001b: r1b = d;
      15'h001c: r1c = d;
      default:  ;
    endcase
  endtask
  task automatic rd(logic [14:0] a);
    exp_q.push_back(shadow(a));
    nm_q.push_back($sformatf("read %h", a));
    frame(1'b1, a, 8'h00, rd_val);
    ->rd_evt;
  endtask
  task automatic check_outs();
    logic [11:0] e;
    wait_c(4);
    e = {1'b0, r1a[6:0], r19[0], r19[3], r19[2], r19[1]} | {12{r1a[7]}};
    chk("sleeps", sl, e);
    chk("dividers", {div_on, conv_on}, r1c[7:6] & {2{~r1a[7]}});
    chk("lock fields", {win_w, win_on, tgt}, r1b[6:0]);
    chk("force", force_u, r1c[2]);
    chk("amplitude", amp, r19[5:4]);
  endtask
  task automatic tk(logic n, logic w);
    i_in_narrow <= n;
    i_in_wide <= w;
    wait_c(3);
    i_pfd_tick <= 1'b1;
    wait_c(5);
    i_pfd_tick <= 1'b0;
    wait_c(5);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************
  // watcher, watchdog and sequence
  // ****************************************
  initial begin
    forever begin
      @(rd_evt);
      chk(nm_q.pop_front(), rd_val, exp_q.pop_front());
    end
  end
  initial begin
    #500000;
    err_total++;
    report_and_stop();
  end
  initial begin
    wait_c(20);
    i_rstn <= 1'b1;
    wait_c(3);
    check_outs();
    for (int a = 'h19; a <= 'h1c; a++) rd(a[14:0]);
    $display("test reset values done");
    wr(`PDLC_OFS_BLOCK_PD, 8'h00);
    check_outs();
    for (int b = 0; b < 7; b++) begin
      wr(`PDLC_OFS_BLOCK_PD, 8'h01 << b);
      check_outs();
    end
    for (int b = 0; b < 4; b++) begin
      wr(`PDLC_OFS_OUT_PWR, 8'h01 << b);
      check_outs();
    end
    wr(`PDLC_OFS_OUT_PWR, $random(seed));
    rd(`PDLC_OFS_OUT_PWR);
    check_outs();
    $display("test sleep bits done");
    wr(`PDLC_OFS_LOCK_CFG, $random(seed));
    wr(`PDLC_OFS_CAL_CLK, 8'hc0);
    wr(`PDLC_OFS_BLOCK_PD, 8'h80);
    check_outs();
    rd(`PDLC_OFS_LOCK_CFG);
    rd(`PDLC_OFS_CAL_CLK);
    wr(`PDLC_OFS_BLOCK_PD, 8'h00);
    check_outs();
    $display("test main sleep done");
    wr(`PDLC_OFS_CAL_CLK, 8'h00);
    wr(`PDLC_OFS_LOCK_CFG, 8'ha3);
    for (int i = 0; i < 4; i++) begin
      tk(1'b1, 1'b0);
      chk("locked narrow", locked, i == 3);
    end
    tk(1'b0, 1'b1);
    chk("locked lost", locked, 1'b0);
    wr(`PDLC_OFS_LOCK_CFG, 8'he3);
    for (int i = 0; i < 4; i++) begin
      tk(1'b0, 1'b1);
      chk("locked wide", locked, i == 3);
    end
    wr(`PDLC_OFS_CAL_CLK, 8'h04);
    check_outs();
    for (int i = 0; i < 5; i++) tk(1'b1, 1'b1);
    chk("locked forced", locked, 1'b0);
    wr(`PDLC_OFS_LOCK_CFG, 8'h82);
    wr(`PDLC_OFS_CAL_CLK, 8'h00);
    for (int i = 0; i < 3; i++) begin
      tk(1'b0, 1'b0);
      chk("locked no window", locked, i == 2);
    end
    wr(`PDLC_OFS_LOCK_CFG, 8'h22);
    tk(1'b0, 1'b0);
    chk("locked kept", locked, 1'b1);
    $display("test lock detector done");
    wr(15'h001d, 8'hff);
    rd(15'h001d);
    rd(15'h0018);
    check_outs();
    $display("test unmapped done");
    wait_c(5);
    report_and_stop();
  end
endmodule // tb_power_down_and_lock_control
